//--- host_cpu_model.sv
// host processor model that runs bus cycles on the asynchronous port
`timescale 1ns/1ps
module host_cpu_model (
  input  wire logic                       clk,
  output logic                            chipSelect_n,
  output logic                            access_strobe_n,
  output logic                            readWrite,
  output logic [tsi_pkg::ADDR_W-1:0]      host_addr,
  output logic [tsi_pkg::DATA_W-1:0]      hostBusIn,
  input  wire logic [tsi_pkg::DATA_W-1:0] hostBusOut,
  input  wire logic                       hostBusOe,
  input  wire logic                       transfer_ack,
  input  wire logic                       transferAckOe
);
  logic [15:0] driveVal = 16'h0000;
  logic        hostDrives = 1'b0;
  logic        oeBad = 1'b0;
  logic        ackWire;
  initial begin
    chipSelect_n    = 1'b1;
    access_strobe_n = 1'b1;
    readWrite       = 1'b1;
    host_addr       = 16'h0000;
  end
  // pull-up holds the acknowledge high once it floats
  assign ackWire = transferAckOe ? transfer_ack : 1'b1;
  // released lines show the inverse so a stale value cannot pass
  assign hostBusIn = hostBusOe ? hostBusOut : (hostDrives ? driveVal : ~driveVal);
  always @(posedge clk) begin
    if (hostBusOe === 1'b1 && (readWrite !== 1'b1 || chipSelect_n !== 1'b0)) oeBad <= 1'b1;
  end
  task automatic access(input logic rw, input logic [15:0] a, input logic [15:0] wd,
                        output logic [15:0] rd, output logic ok, output logic hi);
    int n;
    ok = 1'b0;
    rd = 16'h0000;
    @(negedge clk);
    chipSelect_n    = 1'b0;
    access_strobe_n = 1'b0;
    readWrite       = rw;
    host_addr       = a;
    driveVal        = wd;
    hostDrives      = ~rw;
    for (n = 0; n < 20 && !ok; n++) begin
      @(posedge clk);
      if (ackWire === 1'b0) begin
        ok = 1'b1;
        rd = hostBusIn;
      end
    end
    @(negedge clk);
    chipSelect_n    = 1'b1;
    access_strobe_n = 1'b1;
    hostDrives      = 1'b0;
    @(posedge clk);
    @(posedge clk);
    hi = (transferAckOe === 1'b1) && (transfer_ack === 1'b1);
    @(posedge clk);
    hi = hi && (transferAckOe === 1'b0);
  endtask
endmodule // host_cpu_model

//--- tsi_host_port.sv
// host port, master output control and frame timing of the slot switch
// Functional notes
// - select low opens the processor port
// - strobe with select gates read and write
// - direction input picks read or write
// - acknowledge low marks transfer done
// - acknowledge drives high, then floats
// - 16-bit address reaches all memory words
// - drive enable and standby low: outputs float
// - drive enable high enables output drivers
// - per-channel mode can still float channel
// - reset clears state, floats outputs and data
// - serial data shifted on stream clock
// - frame pulse convention detected automatically
// - frame evaluation measured against frame pulse
// - 32 input and output streams switched
// - 512 channels per frame, equal rates
`timescale 1ns/1ps
module tsi_host_port #(
  parameter int STREAMS  = tsi_pkg::STREAMS,
  parameter int CHANNELS = tsi_pkg::CHANNELS
) (
  input  wire logic                        clk,
  input  wire logic                        reset_n,
  input  wire logic                        chipSelect_n,
  input  wire logic                        access_strobe_n,
  input  wire logic                        readWrite,
  input  wire logic [tsi_pkg::ADDR_W-1:0]  host_addr,
  input  wire logic [tsi_pkg::DATA_W-1:0]  hostBusIn,
  output logic      [tsi_pkg::DATA_W-1:0]  hostBusOut,
  output logic                             hostBusOe,
  output logic                             transfer_ack,
  output logic                             transferAckOe,
  input  wire logic                        master_drive_enable,
  input  wire logic                        outputStandby,
  input  wire logic                        stream_shift_clock,
  input  wire logic                        frame_sync_in,
  input  wire logic                        frame_eval_in,
  input  wire logic [STREAMS-1:0]          serial_in_streams,
  output logic      [STREAMS-1:0]          serial_out_streams,
  output logic      [STREAMS-1:0]          serialOutOe,
  output logic                             frameConventionGci,
  output logic                             offsetValid,
  input  wire logic                        offsetReady,
  output logic      [tsi_pkg::OFFSET_W-1:0] offsetData
);
  tsi_pkg::host_state_t                  hostState_reg;
  logic [tsi_pkg::ADDR_W-1:0]            addr_reg;
  logic [tsi_pkg::DATA_W-1:0]            wdata_reg;
  logic                                  read_reg;
  logic [tsi_pkg::DATA_W-1:0]            hostData_reg;
  logic [tsi_pkg::DATA_W-1:0]            hostRd [STREAMS];
  logic                                  selActive;
  logic [tsi_pkg::STREAM_W-1:0]          addrStream;
  logic                                  shiftPrev_reg;
  logic                                  shiftEdge;
  logic                                  syncLast_reg;
  logic                                  idleLevel_reg;
  logic [1:0]                            runCnt_reg;
  logic                                  frameStart;
  logic [tsi_pkg::BIT_CNT_W-1:0]         bitCnt_reg;
  logic [tsi_pkg::CH_W-1:0]              chan;
  logic [tsi_pkg::BIT_IDX_W-1:0]         bitIdx;
  logic                                  globalEnable;
  logic [STREAMS-1:0]                    chanHiZ;
  logic                                  evalPrev_reg;
  logic                                  armed_reg;
  logic [tsi_pkg::OFFSET_W-1:0]          offsetCnt_reg;
  logic                                  pushValid_reg;
  logic [tsi_pkg::OFFSET_W-1:0]          pushData_reg;
  logic                                  pushReady;

  // ---------------- host port ----------------
  assign selActive = !chipSelect_n && !access_strobe_n;
  // address bits above the stream field are not decoded
  assign addrStream = addr_reg[tsi_pkg::ADDR_ST_LO+tsi_pkg::STREAM_W-1:tsi_pkg::ADDR_ST_LO];

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      hostState_reg <= tsi_pkg::HOST_IDLE;
    end else begin
      unique case (hostState_reg)
        tsi_pkg::HOST_IDLE: begin
          if (selActive) begin
            hostState_reg <= tsi_pkg::HOST_ACCESS;
          end
        end
        tsi_pkg::HOST_ACCESS: begin
          hostState_reg <= selActive ? tsi_pkg::HOST_FETCH : tsi_pkg::HOST_IDLE;
        end
        tsi_pkg::HOST_FETCH: begin
          hostState_reg <= selActive ? tsi_pkg::HOST_ACK : tsi_pkg::HOST_IDLE;
        end
        tsi_pkg::HOST_ACK: begin
          if (!selActive) begin
            hostState_reg <= tsi_pkg::HOST_RELEASE;
          end
        end
        tsi_pkg::HOST_RELEASE: begin
          hostState_reg <= tsi_pkg::HOST_IDLE;
        end
      endcase
    end
  end

  // address, direction and write word are sampled only while the strobe is live
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      addr_reg  <= '0;
      wdata_reg <= '0;
      read_reg  <= 1'b0;
    end else if (hostState_reg == tsi_pkg::HOST_IDLE && selActive) begin
      addr_reg  <= host_addr;
      wdata_reg <= hostBusIn;
      read_reg  <= readWrite;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      hostData_reg <= '0;
    end else if (hostState_reg == tsi_pkg::HOST_FETCH) begin
      hostData_reg <= hostRd[addrStream];
    end
  end

  assign hostBusOut    = hostData_reg;
  // gated by live select so the bus floats the moment the host lets go
  assign hostBusOe     = (hostState_reg == tsi_pkg::HOST_ACK) && read_reg
                         && readWrite && selActive;
  assign transfer_ack  = (hostState_reg != tsi_pkg::HOST_ACK);
  assign transferAckOe = (hostState_reg == tsi_pkg::HOST_ACK)
                         || (hostState_reg == tsi_pkg::HOST_RELEASE);

  // ---------------- frame timing ----------------
  assign shiftEdge = stream_shift_clock && !shiftPrev_reg;

  // the level sampled on three successive shift edges is idle; the pulse is its opposite
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      shiftPrev_reg <= 1'b0;
      syncLast_reg  <= 1'b1;
      idleLevel_reg <= 1'b1;
      runCnt_reg    <= 2'h0;
    end else begin
      shiftPrev_reg <= stream_shift_clock;
      if (shiftEdge) begin
        syncLast_reg <= frame_sync_in;
        if (frame_sync_in != syncLast_reg) begin
          runCnt_reg <= 2'h0;
        end else if (runCnt_reg != 2'h3) begin
          runCnt_reg <= runCnt_reg + 2'h1;
        end
        if (frame_sync_in == syncLast_reg && runCnt_reg == tsi_pkg::RUN_IDLE) begin
          idleLevel_reg <= frame_sync_in;
        end
      end
    end
  end

  assign frameConventionGci = !idleLevel_reg;
  assign frameStart = shiftEdge && (frame_sync_in != idleLevel_reg)
                      && (syncLast_reg == idleLevel_reg);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bitCnt_reg <= '0;
    end else if (frameStart) begin
      bitCnt_reg <= '0;
    end else if (shiftEdge) begin
      bitCnt_reg <= bitCnt_reg + 1'b1;
    end
  end

  assign chan   = bitCnt_reg[tsi_pkg::BIT_CNT_W-1:tsi_pkg::BIT_IDX_W];
  assign bitIdx = bitCnt_reg[tsi_pkg::BIT_IDX_W-1:0];

  // ---------------- serial outputs ----------------
  assign globalEnable = master_drive_enable || outputStandby;

  genvar s;
  generate
    for (s = 0; s < STREAMS; s++) begin : g_stream
      logic [tsi_pkg::DATA_W-1:0] connMem [CHANNELS];
      logic [tsi_pkg::DATA_W-1:0] connWord_reg;
      logic [tsi_pkg::DATA_W-1:0] hostRd_reg;
      logic [1:0]                 mode;
      logic [tsi_pkg::STREAM_W-1:0] srcStream;

      always_ff @(posedge clk) begin
        if (hostState_reg == tsi_pkg::HOST_ACCESS && selActive && !read_reg
            && addrStream == s) begin
          connMem[addr_reg[tsi_pkg::ADDR_ST_LO-1:tsi_pkg::ADDR_CH_LO]] <= wdata_reg;
        end
        hostRd_reg   <= connMem[addr_reg[tsi_pkg::ADDR_ST_LO-1:tsi_pkg::ADDR_CH_LO]];
        connWord_reg <= connMem[chan];
      end

      assign hostRd[s]  = hostRd_reg;
      assign mode       = connWord_reg[tsi_pkg::MOD_HI:tsi_pkg::MOD_LO];
      assign srcStream  = connWord_reg[tsi_pkg::SRC_ST_LO+tsi_pkg::STREAM_W-1:tsi_pkg::SRC_ST_LO];
      assign chanHiZ[s] = (mode == tsi_pkg::MOD_HIZ);

      // processor mode sends the low byte msb first; others pass the chosen input
      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          serial_out_streams[s] <= 1'b0;
          serialOutOe[s]        <= 1'b0;
        end else begin
          serialOutOe[s] <= globalEnable && !chanHiZ[s];
          if (shiftEdge) begin
            serial_out_streams[s] <= (mode == tsi_pkg::MOD_PROC)
              ? connWord_reg[tsi_pkg::BYTE_HI - bitIdx]
              : serial_in_streams[srcStream];
          end
        end
      end
    end
  endgenerate

  // ---------------- frame evaluation ----------------
  // a stalled reader holds the pending word and pauses new measurements
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      evalPrev_reg  <= 1'b0;
      armed_reg     <= 1'b0;
      offsetCnt_reg <= '0;
      pushValid_reg <= 1'b0;
      pushData_reg  <= '0;
    end else begin
      evalPrev_reg <= frame_eval_in;
      if (pushValid_reg && pushReady) begin
        pushValid_reg <= 1'b0;
      end
      if (frameStart) begin
        offsetCnt_reg <= '0;
        armed_reg     <= 1'b1;
      end else begin
        if (offsetCnt_reg != tsi_pkg::OFFSET_MAX) begin
          offsetCnt_reg <= offsetCnt_reg + 1'b1;
        end
        if (armed_reg && frame_eval_in && !evalPrev_reg
            && !(pushValid_reg && !pushReady)) begin
          pushValid_reg <= 1'b1;
          pushData_reg  <= offsetCnt_reg;
          armed_reg     <= 1'b0;
        end
      end
    end
  end

  two_entry_buffer #(.WIDTH(tsi_pkg::OFFSET_W)) u_offset_buffer (
    .clk      (clk),
    .reset_n  (reset_n),
    .inValid  (pushValid_reg),
    .inReady  (pushReady),
    .inData   (pushData_reg),
    .outValid (offsetValid),
    .outReady (offsetReady),
    .outData  (offsetData)
  );

  // ---------------- checks ----------------
  property p_ack_select;
    @(posedge clk) disable iff (!reset_n)
      (transferAckOe && !transfer_ack) |-> $past(!chipSelect_n);
  endproperty
  a_ack_select: assert property (p_ack_select) else $error("ack without select");

  property p_data_strobe;
    @(posedge clk) disable iff (!reset_n)
      hostBusOe |-> (!chipSelect_n && !access_strobe_n);
  endproperty
  a_data_strobe: assert property (p_data_strobe) else $error("data driven without strobe");

  property p_data_dir;
    @(posedge clk) disable iff (!reset_n) hostBusOe |-> (readWrite && read_reg);
  endproperty
  a_data_dir: assert property (p_data_dir) else $error("data driven on write");

  property p_ack_time;
    @(posedge clk) disable iff (!reset_n)
      (hostState_reg == tsi_pkg::HOST_IDLE && selActive) ##1 selActive ##1 selActive
        |=> (transferAckOe && !transfer_ack);
  endproperty
  a_ack_time: assert property (p_ack_time) else $error("ack not given in time");

  property p_ack_release;
    @(posedge clk) disable iff (!reset_n)
      (hostState_reg == tsi_pkg::HOST_ACK && !selActive)
        |=> (transferAckOe && transfer_ack) ##1 !transferAckOe;
  endproperty
  a_ack_release: assert property (p_ack_release) else $error("ack not released high");

  property p_master_off;
    @(posedge clk) disable iff (!reset_n)
      (!master_drive_enable && !outputStandby) |=> (serialOutOe == '0);
  endproperty
  a_master_off: assert property (p_master_off) else $error("outputs driven while off");

  property p_master_on;
    @(posedge clk) disable iff (!reset_n)
      (master_drive_enable && !chanHiZ[3]) |=> serialOutOe[3];
  endproperty
  a_master_on: assert property (p_master_on) else $error("output not enabled");

  property p_chan_hiz;
    @(posedge clk) disable iff (!reset_n) chanHiZ[4] |=> !serialOutOe[4];
  endproperty
  a_chan_hiz: assert property (p_chan_hiz) else $error("floating channel driven");

  property p_reset_float;
    @(posedge clk) !reset_n |-> (serialOutOe == '0 && !hostBusOe && !transferAckOe);
  endproperty
  a_reset_float: assert property (p_reset_float) else $error("drive during reset");

  property p_frame_zero;
    @(posedge clk) disable iff (!reset_n) frameStart |=> (bitCnt_reg == '0);
  endproperty
  a_frame_zero: assert property (p_frame_zero) else $error("frame count not cleared");

  c_read:  cover property (@(posedge clk) disable iff (!reset_n) hostBusOe);
  c_write: cover property (@(posedge clk) disable iff (!reset_n)
    hostState_reg == tsi_pkg::HOST_ACK && !read_reg);
  c_gci:   cover property (@(posedge clk) disable iff (!reset_n) frameConventionGci);
  c_meas:  cover property (@(posedge clk) disable iff (!reset_n) offsetValid && offsetReady);
endmodule // tsi_host_port

//--- tsi_host_port_output_control_tb.sv
// self-checking bench for the host port and output control block
`timescale 1ns/1ps
module tsi_host_port_output_control_tb;
  logic        clk = 1'b0;
  logic        reset_n = 1'b1;
  logic        shiftClk = 1'b0;
  logic        frameSync = 1'b1;
  logic        evalIn = 1'b0;
  logic        mde = 1'b0;
  logic        standby = 1'b0;
  logic        offsetReady = 1'b0;
  logic        gciMode = 1'b0;
  logic [31:0] rxIn = 32'h0000ea2e;
  logic [15:0] lfsrState = 16'hea2e;
  logic        csN, strobeN, rw, hostBusOe, ack, ackOe, gci, offsetValid;
  logic [15:0] addr, busIn, busOut, offsetData;
  logic [31:0] serialOut, serialOutOe;
  int          error_cnt = 0;
  int          n_tests = 0;
  int          frameNo = 0;
  int          bitCnt = 0;
  initial forever #5 clk = ~clk;
  initial forever #15.259 shiftClk = ~shiftClk;
  always @(negedge shiftClk) begin
    bitCnt = (bitCnt + 1) % (tsi_pkg::CHANNELS * 8);
    frameSync = (bitCnt == 0) ? gciMode : ~gciMode;
    if (bitCnt == 0) frameNo++;
  end
  always @(negedge clk) rxIn <= {rxIn[30:0], ^(rxIn & 32'h80200003)};
  host_cpu_model cpu_u (.clk(clk), .chipSelect_n(csN), .access_strobe_n(strobeN),
    .readWrite(rw), .host_addr(addr), .hostBusIn(busIn), .hostBusOut(busOut),
    .hostBusOe(hostBusOe), .transfer_ack(ack), .transferAckOe(ackOe));
  tsi_host_port dut_u (.clk(clk), .reset_n(reset_n), .chipSelect_n(csN),
    .access_strobe_n(strobeN), .readWrite(rw), .host_addr(addr), .hostBusIn(busIn),
    .hostBusOut(busOut), .hostBusOe(hostBusOe), .transfer_ack(ack), .transferAckOe(ackOe),
    .master_drive_enable(mde), .outputStandby(standby), .stream_shift_clock(shiftClk),
    .frame_sync_in(frameSync), .frame_eval_in(evalIn), .serial_in_streams(rxIn),
    .serial_out_streams(serialOut), .serialOutOe(serialOutOe), .frameConventionGci(gci),
    .offsetValid(offsetValid), .offsetReady(offsetReady), .offsetData(offsetData));
  function automatic logic [15:0] lfsr();
    lfsrState = {lfsrState[14:0], lfsrState[15] ^ lfsrState[13] ^ lfsrState[12] ^ lfsrState[10]};
    return lfsrState;
  endfunction
  function automatic logic hasByte(input logic [17:0] c);
    for (int i = 0; i <= 10; i++)
      if (c[i+:8] === 8'ha5) return 1'b1;
    return 1'b0;
  endfunction
  // detection lags on both events differ by a few cycles
  function automatic logic near(input logic [15:0] g, input int e);
    return (int'(g) - e <= 5) && (e - int'(g) <= 5);
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("comparisons=%0d mismatches=%0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic wait_frame();
    int n;
    int f;
    f = frameNo;
    for (n = 0; n < 14000 && frameNo == f; n++) @(negedge clk);
    if (frameNo == f) begin
      check(32'h1, 32'h0);
      report_and_stop();
    end
  endtask
  task automatic bus(input logic wr, input logic [15:0] a, input logic [15:0] wd,
                     output logic [15:0] rd);
    logic ok;
    logic hi;
    cpu_u.access(wr, a, wd, rd, ok, hi);
    check(ok, 1'b1);
    check(hi, 1'b1);
    if (ok !== 1'b1) report_and_stop();
  endtask
  initial begin
    logic [15:0] a;
    logic [15:0] w;
    logic [15:0] r;
    logic [17:0] cap;
    logic        o4a;
    logic        o4b;
    logic        o3;
    logic        o3s;
    int          d[4];
    logic [15:0] got[$];
    int          n;
    // a real falling edge on reset so the async branch fires before the first clock
    #1 reset_n = 1'b0;
    repeat (8) @(negedge clk);
    check(serialOutOe, 32'h0);
    check({hostBusOe, ackOe, offsetValid}, 3'h0);
    reset_n = 1'b1;
    for (n = 0; n < 10; n++) begin
      a = lfsr();
      a[14] = 1'b0;
      a[12] = 1'b1; // keeps the random words off streams 3 and 4
      if (n == 0) a = 16'h3fff;
      w = (n == 1) ? 16'hffff : lfsr();
      bus(1'b0, a, w, r);
      bus(1'b1, a ^ 16'h8000, 16'h0000, r);
      check(r, w);
    end
    bus(1'b0, 16'h0600, 16'h00a5, r);
    bus(1'b0, 16'h0601, 16'h0000, r);
    bus(1'b0, 16'h0800, 16'hc000, r);
    bus(1'b0, 16'h0801, 16'h0000, r);
    repeat (3) @(negedge clk);
    check(serialOutOe, 32'h0);
    standby = 1'b1;
    wait_frame();
    cap = '0;
    for (n = 0; n < 18; n++) begin
      @(negedge shiftClk);
      cap = {cap[16:0], serialOut[3]};
      if (n == 5) o4a = serialOutOe[4];
      if (n == 5) o3s = serialOutOe[3];
      if (n == 6) begin
        @(negedge clk);
        standby = 1'b0;
        mde = 1'b1;
      end
      if (n == 14) o4b = serialOutOe[4];
      if (n == 14) o3 = serialOutOe[3];
    end
    check(o3s, 1'b1);
    check(o4a, 1'b0);
    check(o4b, 1'b1);
    check(o3, 1'b1);
    check(hasByte(cap), 1'b1);
    for (n = 0; n < 4; n++) begin
      wait_frame();
      d[n] = 100 + (lfsr() & 16'h03ff);
      repeat (d[n]) @(negedge clk);
      evalIn = 1'b1;
      repeat (20) @(negedge clk);
      evalIn = 1'b0;
    end
    offsetReady = 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge clk);
      if (offsetValid === 1'b1) got.push_back(offsetData);
    end
    check(got.size(), 3);
    for (n = 0; n < 3 && n < got.size(); n++) check(near(got[n], d[n]), 1'b1);
    check(gci, 1'b0);
    gciMode = 1'b1;
    wait_frame();
    wait_frame();
    check(gci, 1'b1);
    @(negedge clk);
    reset_n = 1'b0;
    repeat (2) @(negedge clk);
    check(serialOutOe, 32'h0);
    check({hostBusOe, ackOe, offsetValid, gci}, 4'h0);
    reset_n = 1'b1;
    check(cpu_u.oeBad, 1'b0);
    report_and_stop();
  end
endmodule // tsi_host_port_output_control_tb

//--- tsi_pkg.sv
// shared constants and types for the host port and output control block
package tsi_pkg;
  localparam int ADDR_W        = 16;
  localparam int DATA_W        = 16;
  localparam int STREAMS       = 32;
  localparam int STREAM_W      = 5;
  localparam int CHANNELS      = 512;
  localparam int CH_W          = 9;
  localparam int BIT_CNT_W     = 12;
  localparam int BIT_IDX_W     = 3;
  localparam int OFFSET_W      = 16;
  // host address layout: stream above channel
  localparam int ADDR_CH_LO    = 0;
  localparam int ADDR_ST_LO    = 9;
  // connection word layout
  localparam int MOD_HI        = 15;
  localparam int MOD_LO        = 14;
  localparam int SRC_ST_LO     = 8;
  localparam int BYTE_HI       = 7;
  localparam logic [1:0] MOD_PROC = 2'h0;
  localparam logic [1:0] MOD_HIZ  = 2'h3;
  // timing
  localparam int CLK_PERIOD_PS     = 10000;
  localparam int RESET_MIN_NS      = 20;
  localparam int RESET_MIN_CYCLES  =
    (RESET_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int SHIFT_CLK_KHZ     = 32768;
  localparam logic [1:0] RUN_IDLE  = 2'h1;
  localparam logic [OFFSET_W-1:0] OFFSET_MAX = 16'hffff;
  typedef enum logic [2:0] {HOST_IDLE, HOST_ACCESS, HOST_FETCH, HOST_ACK, HOST_RELEASE}
    host_state_t;
endpackage

//--- two_entry_buffer.sv
// two-entry valid/ready buffer for frame offset measurements
`timescale 1ns/1ps
module two_entry_buffer #(
  parameter int WIDTH = 16
) (
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);
  logic [WIDTH-1:0] slot_reg [2];
  logic             wrPtr_reg;
  logic             rdPtr_reg;
  logic [1:0]       count_reg;
  logic             push;
  logic             pop;

  assign inReady  = (count_reg != 2'h2);
  assign outValid = (count_reg != 2'h0);
  assign outData  = slot_reg[rdPtr_reg];
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;

  always_ff @(posedge clk) begin
    if (push) begin
      slot_reg[wrPtr_reg] <= inData;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wrPtr_reg <= 1'b0;
      rdPtr_reg <= 1'b0;
      count_reg <= 2'h0;
    end else begin
      if (push) begin
        wrPtr_reg <= ~wrPtr_reg;
      end
      if (pop) begin
        rdPtr_reg <= ~rdPtr_reg;
      end
      count_reg <= count_reg + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule // two_entry_buffer
